// *** hdl/ssfc_pkg.sv ***
// Constants and types for the sideband scaling and frame control block
//********************************************************************
//********************************************************************
package ssfc_pkg;

    //********************************************************************
    // Register map
    //********************************************************************
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_TIME_WEEK  = 8'h04;
    localparam logic [7:0] REG_TIME_SEC   = 8'h08;
    localparam logic [7:0] REG_CMD        = 8'h0C;
    localparam logic [7:0] REG_FRAME_NUM  = 8'h10;
    localparam logic [7:0] REG_STATUS     = 8'h14;

    // Control fields
    localparam int CTRL_RBW  = 0;
    localparam int CTRL_HPID = 1;
    localparam int CTRL_PL   = 2;
    localparam int CTRL_AAB  = 3;
    localparam int CTRL_MODE = 4;
    localparam int CMD_LOAD  = 0;
    localparam int STAT_MODE = 8;

    localparam logic [4:0] MODE_HYBRID      = 5'h01;
    localparam logic [4:0] MODE_ALL_DIGITAL = 5'h02;

    // Time base
    localparam logic [33:0] SEC_PER_WEEK     = 34'h0000093A80;
    localparam int unsigned BLOCKS_PER_FRAME = 8;
    localparam logic [3:0]  BLOCK_LAST       = 4'h7;
    localparam int unsigned BLOCK_CYCLES_DEF = 1000000;
    localparam logic [15:0] RATE_MUL_DEF     = 16'hAC44;
    localparam int          RATE_SHIFT_DEF   = 16;

    typedef enum logic [2:0] {
        SC_OFF      = 3'h0,
        SC_HYB_LOW  = 3'h1,
        SC_HYB_MED  = 3'h2,
        SC_HYB_HIGH = 3'h3,
        SC_AD_STD   = 3'h4,
        SC_AD_HIGH  = 3'h5,
        SC_AD_ENH   = 3'h6
    } ssfc_scale_t;

endpackage

// *** hdl/ssfc_top.sv ***
// Sideband scaling selection, frame numbering and block counting
`timescale 1ns/1ps
module ssfc_top
    import ssfc_pkg::*;
#(
    parameter int unsigned BLOCK_CYCLES = BLOCK_CYCLES_DEF,
    parameter logic [15:0] RATE_MUL     = RATE_MUL_DEF,
    parameter int          RATE_SHIFT   = RATE_SHIFT_DEF
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // Scale selections to the subcarrier mapper
    output ssfc_scale_t      sid2_scale,
    output ssfc_scale_t      sid1_scale,
    output ssfc_scale_t      secondary_scale,
    output ssfc_scale_t      tertiary_scale,
    // Indicators for the reference carrier sequence
    output logic             ind_reduced_bw,
    output logic             ind_high_power_id,
    output logic             ind_power_level,
    output logic             audio_8khz,
    output logic [2:0]       ref_block_count,
    // Control channel to layer 2
    output logic [31:0]      l2_frame_number,
    output logic             l2_frame_strobe,
    output logic [2:0]       l2_block_count,
    output logic             l2_block_strobe
);

    //********************************************************************
    // Staged software controls
    //********************************************************************
    logic        reduced_bandwidth;
    logic        high_power_id;
    logic        power_level;
    logic        audio_bandwidth_select;
    logic [4:0]  service_mode;
    logic [9:0]  week;
    logic [3:0]  epoch_count;
    logic [19:0] week_seconds;
    logic        load_pend;
    logic [4:0]  applied_mode;

    wire wr_ctrl = wr && (addr == REG_CTRL);
    wire wr_cmd  = wr && (addr == REG_CMD);

    // Writes land in staging only; nothing reaches the mapper mid-frame
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reduced_bandwidth      <= 1'b0;
            high_power_id          <= 1'b0;
            power_level            <= 1'b0;
            audio_bandwidth_select <= 1'b0;
            service_mode           <= 5'h00;
        end else if (wr_ctrl) begin
            reduced_bandwidth      <= wdata[CTRL_RBW];
            high_power_id          <= wdata[CTRL_HPID];
            power_level            <= wdata[CTRL_PL];
            audio_bandwidth_select <= wdata[CTRL_AAB];
            service_mode           <= wdata[CTRL_MODE +: 5];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            week         <= 10'h000;
            epoch_count  <= 4'h0;
            week_seconds <= 20'h00000;
        end else if (wr && addr == REG_TIME_WEEK) begin
            week        <= wdata[9:0];
            epoch_count <= wdata[13:10];
        end else if (wr && addr == REG_TIME_SEC) begin
            week_seconds <= wdata[19:0];
        end
    end

    //********************************************************************
    // Block and frame timing
    //********************************************************************
    logic [31:0] cycle_cnt;
    logic [3:0]  block_count;
    logic        block_tick;
    logic        frame_tick;

    assign block_tick = (cycle_cnt == 32'(BLOCK_CYCLES - 1));
    assign frame_tick = block_tick && (block_count == BLOCK_LAST);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cycle_cnt <= 32'h00000000;
        end else if (block_tick) begin
            cycle_cnt <= 32'h00000000;
        end else begin
            cycle_cnt <= cycle_cnt + 32'h00000001;
        end
    end

    // Top bit never set: the counter wraps at the last block
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            block_count <= 4'h0;
        end else if (frame_tick) begin
            block_count <= 4'h0;
        end else if (block_tick) begin
            block_count <= block_count + 4'h1;
        end
    end

    //********************************************************************
    // Absolute frame number
    //********************************************************************
    // Epoch count extends the week number so a rollover does not reset time
    logic [13:0] total_weeks;
    logic [33:0] elapsed_sec;
    logic [49:0] scaled_sec;
    logic [31:0] frame_calc;
    logic [31:0] frame_number;

    assign total_weeks = {epoch_count, week};
    assign elapsed_sec = 34'(total_weeks) * SEC_PER_WEEK + 34'(week_seconds);
    assign scaled_sec  = 50'(elapsed_sec) * 50'(RATE_MUL);
    assign frame_calc  = scaled_sec[RATE_SHIFT +: 32];

    // A load request raised in the boundary cycle survives for the next one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            load_pend <= 1'b0;
        end else if (wr_cmd && wdata[CMD_LOAD]) begin
            load_pend <= 1'b1;
        end else if (frame_tick) begin
            load_pend <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            frame_number <= 32'h00000000;
        end else if (frame_tick) begin
            frame_number <= load_pend ? frame_calc : frame_number + 32'h00000001;
        end
    end

    //********************************************************************
    // Scale selection, computed from staging and applied at the boundary
    //********************************************************************
    ssfc_scale_t next_sid2;
    ssfc_scale_t next_sid1;
    ssfc_scale_t next_sec;
    ssfc_scale_t next_ter;
    logic        next_aab;

    always_comb begin
        next_sid2 = SC_OFF;
        next_sid1 = SC_OFF;
        next_sec  = SC_OFF;
        next_ter  = SC_OFF;
        next_aab  = 1'b0;
        if (service_mode == MODE_HYBRID) begin
            next_aab = audio_bandwidth_select;
            if (reduced_bandwidth) begin
                next_sid2 = SC_HYB_HIGH;
                next_sid1 = SC_OFF;
                next_sec  = SC_OFF;
                next_ter  = SC_OFF;
            end else begin
                if (high_power_id) begin
                    next_sid2 = SC_HYB_HIGH;
                end else if (power_level) begin
                    next_sid2 = SC_HYB_MED;
                end else begin
                    next_sid2 = SC_HYB_LOW;
                end
                next_sid1 = power_level ? SC_HYB_HIGH : SC_HYB_LOW;
                next_sec  = power_level ? SC_HYB_HIGH : SC_HYB_LOW;
                next_ter  = power_level ? SC_HYB_HIGH : SC_HYB_LOW;
            end
        end else if (service_mode == MODE_ALL_DIGITAL) begin
            if (reduced_bandwidth || high_power_id) begin
                next_sid2 = SC_AD_HIGH;
                next_sid1 = SC_AD_HIGH;
            end else begin
                next_sid2 = SC_AD_STD;
                next_sid1 = SC_AD_STD;
            end
            next_sec = reduced_bandwidth ? SC_OFF : SC_AD_ENH;
            next_ter = reduced_bandwidth ? SC_OFF : SC_AD_ENH;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sid2_scale        <= SC_OFF;
            sid1_scale        <= SC_OFF;
            secondary_scale   <= SC_OFF;
            tertiary_scale    <= SC_OFF;
            audio_8khz        <= 1'b0;
            ind_reduced_bw    <= 1'b0;
            ind_high_power_id <= 1'b0;
            ind_power_level   <= 1'b0;
            applied_mode      <= 5'h00;
        end else if (frame_tick) begin
            sid2_scale        <= next_sid2;
            sid1_scale        <= next_sid1;
            secondary_scale   <= next_sec;
            tertiary_scale    <= next_ter;
            audio_8khz        <= next_aab;
            ind_reduced_bw    <= reduced_bandwidth;
            ind_high_power_id <= high_power_id;
            ind_power_level   <= power_level;
            applied_mode      <= service_mode;
        end
    end

    //********************************************************************
    // Control channel to layer 2 and reference carrier count
    //********************************************************************
    // Frame number leaves here and through REG_FRAME_NUM reads; the broadcast side sees the count alone
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            l2_frame_number <= 32'h00000000;
            l2_frame_strobe <= 1'b0;
        end else begin
            l2_frame_strobe <= frame_tick;
            if (frame_tick) begin
                l2_frame_number <= load_pend ? frame_calc : frame_number + 32'h00000001;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            l2_block_count  <= 3'h0;
            ref_block_count <= 3'h0;
            l2_block_strobe <= 1'b0;
        end else begin
            l2_block_strobe <= block_tick;
            if (block_tick) begin
                l2_block_count  <= frame_tick ? 3'h0 : 3'(block_count + 4'h1);
                ref_block_count <= frame_tick ? 3'h0 : 3'(block_count + 4'h1);
            end
        end
    end

    //********************************************************************
    // Register read
    //********************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            unique case (addr)
                REG_CTRL:      rdata <= {23'h000000, service_mode, audio_bandwidth_select,
                                         power_level, high_power_id, reduced_bandwidth};
                REG_TIME_WEEK: rdata <= {18'h00000, epoch_count, week};
                REG_TIME_SEC:  rdata <= {12'h000, week_seconds};
                REG_FRAME_NUM: rdata <= frame_number;
                REG_STATUS:    rdata <= {19'h00000, applied_mode, 4'h0, block_count};
                default:       rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    //********************************************************************
    // Assertions
    //********************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    block_wrap_a: assert property (frame_tick |=> block_count == 4'h0 && l2_block_count == 3'h0)
        else $error("block count did not wrap at frame end");
    block_top_a: assert property (block_count[3] == 1'b0)
        else $error("block count top bit set");
    frame_incr_a: assert property (frame_tick && !load_pend && !wr_cmd
                                   |=> frame_number == $past(frame_number) + 32'h00000001)
        else $error("frame number did not advance");
    l2_frame_a: assert property (frame_tick |=> l2_frame_strobe && l2_frame_number == frame_number)
        else $error("frame number not passed to layer 2");
    rbw_off_a: assert property (ind_reduced_bw |-> secondary_scale == SC_OFF
                                && tertiary_scale == SC_OFF)
        else $error("sidebands active under reduced bandwidth");
    hyb_sid1_a: assert property (ind_reduced_bw && applied_mode == MODE_HYBRID
                                 |-> sid1_scale == SC_OFF && sid2_scale == SC_HYB_HIGH)
        else $error("hybrid reduced bandwidth id scaling wrong");
    scale_hold_a: assert property (!frame_tick |=> $stable(secondary_scale) && $stable(sid2_scale))
        else $error("scaling changed away from frame boundary");
    ad_sid_a: assert property (applied_mode == MODE_ALL_DIGITAL
                               |-> sid1_scale == sid2_scale && !audio_8khz)
        else $error("all-digital id groups differ or audio bandwidth set");
    blk_strobe_a: assert property (block_tick |=> l2_block_strobe ##1 !l2_block_strobe)
        else $error("block strobe not one cycle");

    //********************************************************************
    // Block and frame timing checks
    //********************************************************************
    cycle_bound_a: assert property (cycle_cnt < 32'(BLOCK_CYCLES))
        else $error("block cycle counter ran past its period");

    blk_pair_a: assert property (block_tick |=> l2_block_count == ref_block_count)
        else $error("layer 2 and reference block counts differ");

    frm_strobe_a: assert property (frame_tick |=> l2_frame_strobe ##1 !l2_frame_strobe)
        else $error("frame strobe not one cycle");

    frm_quiet_a: assert property (!frame_tick |=> !l2_frame_strobe)
        else $error("frame strobe away from frame boundary");

    load_frame_a: assert property (frame_tick && load_pend
                                   |=> frame_number == $past(frame_calc))
        else $error("frame number not loaded from time");

    //********************************************************************
    // Applied scaling checks, hybrid mode
    //********************************************************************
    // Applied mode and indicators move on the same edge as the scale codes
    hyb_full_a: assert property (!ind_reduced_bw && applied_mode == MODE_HYBRID
                                 |-> sid1_scale == secondary_scale
                                 && secondary_scale == tertiary_scale
                                 && sid1_scale != SC_OFF)
        else $error("hybrid sideband set inconsistent");

    hyb_hpid_a: assert property (!ind_reduced_bw && ind_high_power_id
                                 && applied_mode == MODE_HYBRID |-> sid2_scale == SC_HYB_HIGH)
        else $error("hybrid high power id not applied");

    hyb_low_a: assert property (!ind_reduced_bw && !ind_high_power_id && !ind_power_level
                                && applied_mode == MODE_HYBRID |-> sid2_scale == SC_HYB_LOW)
        else $error("hybrid low id-2 level wrong");

    hyb_med_a: assert property (!ind_reduced_bw && !ind_high_power_id && ind_power_level
                                && applied_mode == MODE_HYBRID |-> sid2_scale == SC_HYB_MED)
        else $error("hybrid medium id-2 level wrong");

    aab_mode_a: assert property (applied_mode != MODE_HYBRID |-> !audio_8khz)
        else $error("audio bandwidth set outside hybrid");

    //********************************************************************
    // Applied scaling checks, all-digital and unknown modes
    //********************************************************************
    ad_rbw_a: assert property (ind_reduced_bw && applied_mode == MODE_ALL_DIGITAL
                               |-> sid2_scale == SC_AD_HIGH)
        else $error("all-digital reduced bandwidth id not high");

    ad_enh_a: assert property (!ind_reduced_bw && applied_mode == MODE_ALL_DIGITAL
                               |-> secondary_scale == SC_AD_ENH && tertiary_scale == SC_AD_ENH)
        else $error("all-digital sidebands not enhanced");

    ad_std_a: assert property (!ind_reduced_bw && !ind_high_power_id
                               && applied_mode == MODE_ALL_DIGITAL |-> sid2_scale == SC_AD_STD)
        else $error("all-digital standard id level wrong");

    ad_high_a: assert property (!ind_reduced_bw && ind_high_power_id
                                && applied_mode == MODE_ALL_DIGITAL |-> sid2_scale == SC_AD_HIGH)
        else $error("all-digital high id level wrong");

    mode_none_a: assert property (applied_mode != MODE_HYBRID
                                  && applied_mode != MODE_ALL_DIGITAL
                                  |-> sid2_scale == SC_OFF && secondary_scale == SC_OFF)
        else $error("scaling active with no service mode");

    //********************************************************************
    // Register port checks
    //********************************************************************
    rd_idle_a: assert property (!rd |=> rdata == 32'h00000000)
        else $error("read data outside read answer cycle");

    rd_frame_a: assert property (rd && addr == REG_FRAME_NUM |=> rdata == $past(frame_number))
        else $error("frame number read wrong");

endmodule

// *** bench/ssfc_l2_model.sv ***
// Layer 2 control channel receiver model with block order checks
`timescale 1ns/1ps
module ssfc_l2_model
#(
    parameter int unsigned BLOCK_CYCLES = 4
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Control channel from the block
    input  wire logic [31:0] l2_frame_number,
    input  wire logic        l2_frame_strobe,
    input  wire logic [2:0]  l2_block_count,
    input  wire logic        l2_block_strobe,
    // Findings
    output int               err_count,
    output int               frame_count
);
    logic [2:0] last_count;
    logic       seen_block;
    int         gap;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            err_count   <= 0;
            frame_count <= 0;
            seen_block  <= 1'b0;
            last_count  <= 3'h0;
            gap         <= 0;
        end else begin
            gap <= l2_block_strobe ? 1 : gap + 1;
            if (l2_block_strobe) begin
                seen_block <= 1'b1;
                last_count <= l2_block_count;
                // Blocks advance by one and wrap 7 to 0, one period apart
                if (seen_block && (l2_block_count !== last_count + 3'h1
                                   || gap != BLOCK_CYCLES))
                    err_count <= err_count + 1;
            end
            // Frame number arrives only with the first block of a frame
            if (l2_frame_strobe) begin
                frame_count <= frame_count + 1;
                if (!l2_block_strobe || l2_block_count !== 3'h0)
                    err_count <= err_count + 1;
            end
        end
    end
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench for the sideband scaling and frame control block
`timescale 1ns/1ps
module testbench
    import ssfc_pkg::*;
;
    localparam int unsigned BC = 4;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata, l2_frame_number;
    ssfc_scale_t sid2_scale, sid1_scale, secondary_scale, tertiary_scale;
    logic        ind_reduced_bw, ind_high_power_id, ind_power_level, audio_8khz;
    logic [2:0]  ref_block_count, l2_block_count;
    logic        l2_frame_strobe, l2_block_strobe;
    int          failures = 0;
    int          cmp_count = 0;
    int          err_count, frame_count;

    always #4 mclk = ~mclk;

    ssfc_top #(.BLOCK_CYCLES(BC), .RATE_MUL(RATE_MUL_DEF), .RATE_SHIFT(RATE_SHIFT_DEF)) dut (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sid2_scale(sid2_scale), .sid1_scale(sid1_scale),
        .secondary_scale(secondary_scale), .tertiary_scale(tertiary_scale),
        .ind_reduced_bw(ind_reduced_bw), .ind_high_power_id(ind_high_power_id),
        .ind_power_level(ind_power_level), .audio_8khz(audio_8khz),
        .ref_block_count(ref_block_count), .l2_frame_number(l2_frame_number),
        .l2_frame_strobe(l2_frame_strobe), .l2_block_count(l2_block_count),
        .l2_block_strobe(l2_block_strobe));

    ssfc_l2_model #(.BLOCK_CYCLES(BC)) l2 (
        .mclk(mclk), .nrst(nrst), .l2_frame_number(l2_frame_number),
        .l2_frame_strobe(l2_frame_strobe), .l2_block_count(l2_block_count),
        .l2_block_strobe(l2_block_strobe), .err_count(err_count),
        .frame_count(frame_count));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test;
        $display("comparisons %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait for the frame strobe; sampled once each edge has landed
    task automatic wait_frame;
        for (int n = 0; n <= 8 * BC + 8; n++) begin
            @(posedge mclk);
            #1;
            if (l2_frame_strobe === 1'b1)
                return;
        end
        failures++;
        $display("mismatch at %0t: frame boundary missing", $time);
        end_of_test();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset;
        logic [31:0] d;
        check({sid2_scale, sid1_scale, secondary_scale, tertiary_scale}, 12'h000);
        bus_rd(8'h3C, d);
        check(d, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_blocks;
        wait_frame();
        for (int b = 0; b < 8; b++) begin
            check({l2_block_count, ref_block_count}, {3'(b), 3'(b)});
            for (int n = 0; n < BC; n++) begin
                check(l2_frame_strobe, b == 0 && n == 0);
                @(posedge mclk);
                #1;
            end
        end
        check(l2_frame_strobe, 1'b1);
        $display("test blocks done");
    endtask

    task automatic test_scaling;
        logic [11:0] prev, exp;
        logic        hyb, rbw, hpid, pl, aab;
        prev = {sid2_scale, sid1_scale, secondary_scale, tertiary_scale};
        for (int i = 0; i < 16; i++) begin
            hyb  = !i[3];
            rbw  = i[2];
            hpid = i[1];
            pl   = i[0];
            // Source drives the audio control low in hybrid reduced bandwidth
            aab  = !rbw || !hyb;
            bus_wr(REG_CTRL, {23'h0, hyb ? MODE_HYBRID : MODE_ALL_DIGITAL,
                              aab, pl, hpid, rbw});
            repeat (2) @(posedge mclk);
            #1 check({sid2_scale, sid1_scale, secondary_scale, tertiary_scale}, prev);
            wait_frame();
            if (hyb && rbw)
                exp = {SC_HYB_HIGH, SC_OFF, SC_OFF, SC_OFF};
            else if (hyb)
                exp = {hpid ? SC_HYB_HIGH : (pl ? SC_HYB_MED : SC_HYB_LOW),
                       {3{pl ? SC_HYB_HIGH : SC_HYB_LOW}}};
            else
                exp = {{2{(rbw | hpid) ? SC_AD_HIGH : SC_AD_STD}},
                       {2{rbw ? SC_OFF : SC_AD_ENH}}};
            check({sid2_scale, sid1_scale, secondary_scale, tertiary_scale}, exp);
            check({ind_reduced_bw, ind_high_power_id, ind_power_level}, {rbw, hpid, pl});
            check(audio_8khz, hyb & aab);
            prev = exp;
        end
        $display("test scaling done");
    endtask

    task automatic test_frame_number;
        logic [31:0] d, fn;
        logic [63:0] secs;
        wait_frame();
        fn = l2_frame_number;
        bus_wr(REG_FRAME_NUM, 32'h0000_FFFF);
        bus_rd(REG_FRAME_NUM, d);
        check(d, fn);
        bus_rd(REG_STATUS, d);
        check(d & 32'h0000_1F08, {19'h0, MODE_ALL_DIGITAL, 8'h00});
        wait_frame();
        check(l2_frame_number, fn + 32'h1);
        bus_wr(REG_TIME_WEEK, 32'h0000_0401);
        bus_wr(REG_TIME_SEC, 32'h0000_0005);
        bus_rd(REG_TIME_WEEK, d);
        check(d, 32'h0000_0401);
        bus_wr(REG_CMD, 32'h0000_0001);
        wait_frame();
        secs = (64'h0000_0000_0000_0401 * 64'(SEC_PER_WEEK) + 64'h5) * 64'(RATE_MUL_DEF);
        fn   = 32'(secs >> RATE_SHIFT_DEF);
        check(l2_frame_number, fn);
        wait_frame();
        check(l2_frame_number, fn + 32'h1);
        $display("test frame number done");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1;
        test_reset();
        test_blocks();
        test_scaling();
        test_frame_number();
        check(err_count, 0);
        end_of_test();
    end
endmodule
